// ==== rtl/flash_host_pkg.sv ====
// Constants, types and register map of the flash disk host port controller
package flash_host_pkg;

  // Timing base
  localparam int CLK_MHZ    = 40;
  localparam int RESET_NS   = 1000;
  localparam int AVD_NS     = 50;
  localparam int STROBE_NS  = 100;
  localparam int RECOVER_NS = 50;
  localparam logic [7:0] RESET_CYC   = 8'((RESET_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] AVD_CYC     = 8'((AVD_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] STROBE_CYC  = 8'((STROBE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] RECOVER_CYC = 8'((RECOVER_NS * CLK_MHZ + 999) / 1000);

  // Device window
  localparam int DEV_AW = 13;
  localparam int DEV_DW = 16;

  // Register offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_DATA   = 8'h08;
  localparam logic [7:0] REG_CMD    = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;

  // Control fields
  localparam int CTRL_MUX   = 0;
  localparam int CTRL_LOCK  = 1;
  localparam int CTRL_WIDE  = 2;
  localparam int CTRL_RERUN = 3;
  localparam int CMD_READ   = 0;

  // Status fields
  localparam int STAT_ACTIVE = 0;
  localparam int STAT_DONE   = 1;
  localparam int STAT_IRQ    = 2;
  localparam int STAT_DMA    = 3;
  localparam int STAT_DBUSY  = 4;
  localparam int STAT_MUX    = 5;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_RESET   = 3'b001,
    ST_MUXEDGE = 3'b010,
    ST_BUSYW   = 3'b011,
    ST_ADDR    = 3'b100,
    ST_STROBE  = 3'b101,
    ST_RECOVER = 3'b110
  } seq_t;

  // Device pin drive
  typedef struct packed {
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic              address_valid_n;
    logic              reset_in_n;
    logic              lock_n;
    logic              if_cfg;
    logic [DEV_AW-1:0] addr;
    logic [DEV_DW-1:0] ad_out;
    logic              ad_oe;
  } pins_t;

  // Whole controller state
  typedef struct packed {
    seq_t              st;
    logic [7:0]        cnt;
    logic              ctrl_mux;
    logic              ctrl_lock;
    logic              ctrl_wide;
    logic [DEV_AW-1:0] addr;
    logic [DEV_DW-1:0] wdata;
    logic [DEV_DW-1:0] rdata;
    logic              is_write;
    logic              mux_active;
    logic              done;
    logic [31:0]       bus_rdata;
    pins_t             pin;
  } state_t;

endpackage

// ==== rtl/flash_host_port.sv ====
// Host controller driving the flash disk system interface pins
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module flash_host_port
  import flash_host_pkg::*;
(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              resetn,
  // Register port
  input  wire logic [7:0]        bus_addr,
  input  wire logic [31:0]       bus_wdata,
  input  wire logic              bus_write,
  input  wire logic              bus_read,
  output logic [31:0]            bus_rdata,
  // Device strobes and address
  output logic                   ce_n,
  output logic                   oe_n,
  output logic                   we_n,
  output logic                   address_valid_n,
  output logic [DEV_AW-1:0]      dev_addr,
  // Device data bus
  input  wire logic [DEV_DW-1:0] ad_in,
  output logic [DEV_DW-1:0]      ad_out,
  output logic                   ad_oe,
  // Device control
  output logic                   reset_in_n,
  output logic                   lock_n,
  output logic                   if_cfg,
  input  wire logic              busy_n,
  input  wire logic              irq_n,
  input  wire logic              dma_request_n
);

  logic [1:0] rst_sync;
  logic       rst_n;
  state_t     q;
  state_t     next_q;

  // Reset release through two flops
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Next state
  always_comb begin
    next_q = q;
    next_q.bus_rdata = 32'h0000_0000;
    next_q.cnt = (q.cnt != 8'h00) ? q.cnt - 8'h01 : 8'h00;
    // lock hold: lock pin follows software lock bit
    next_q.pin.lock_n = ~q.ctrl_lock;
    next_q.pin.if_cfg = q.ctrl_wide;

    // Register reads, one cycle later
    if (bus_read) begin
      unique case (bus_addr)
        REG_CTRL:   next_q.bus_rdata = {29'h0, q.ctrl_wide, q.ctrl_lock, q.ctrl_mux};
        REG_ADDR:   next_q.bus_rdata = {19'h0, q.addr};
        REG_DATA:   next_q.bus_rdata = {16'h0, q.rdata};
        REG_STATUS: next_q.bus_rdata = {26'h0, q.mux_active, ~busy_n, ~dma_request_n,
                                        ~irq_n, q.done, q.st != ST_IDLE};
        default:    next_q.bus_rdata = 32'h0000_0000;
      endcase
      if (bus_addr == REG_STATUS) begin
        next_q.done = 1'b0;
      end
    end

    // Register writes; accesses accepted only while idle
    if (bus_write) begin
      unique case (bus_addr)
        REG_CTRL: begin
          next_q.ctrl_mux  = bus_wdata[CTRL_MUX];
          next_q.ctrl_lock = bus_wdata[CTRL_LOCK];
          next_q.ctrl_wide = bus_wdata[CTRL_WIDE];
          if (bus_wdata[CTRL_RERUN] && q.st == ST_IDLE) begin
            next_q.st = ST_RESET;
            next_q.cnt = RESET_CYC;
            next_q.pin.reset_in_n = 1'b0;
          end
        end
        REG_ADDR: next_q.addr = bus_wdata[DEV_AW-1:0];
        REG_DATA: begin
          if (q.st == ST_IDLE) begin
            next_q.wdata = bus_wdata[DEV_DW-1:0];
            next_q.is_write = 1'b1;
            next_q.st = ST_BUSYW;
          end
        end
        REG_CMD: begin
          if (q.st == ST_IDLE && bus_wdata[CMD_READ]) begin
            next_q.is_write = 1'b0;
            next_q.st = ST_BUSYW;
          end
        end
        default: ;
      endcase
    end

    // Access sequencer
    unique case (q.st)
      ST_IDLE: ;
      ST_RESET: begin
        if (q.cnt == 8'h01) begin
          next_q.pin.reset_in_n = 1'b1;
          next_q.mux_active = 1'b0;
          // mode edge: after reset release, before any access
          if (q.ctrl_mux) begin
            next_q.st = ST_MUXEDGE;
            next_q.cnt = AVD_CYC;
          end else begin
            next_q.st = ST_IDLE;
          end
        end
      end
      ST_MUXEDGE: begin
        // falling edge on address-valid selects mux mode
        next_q.pin.address_valid_n = 1'b0;
        if (q.cnt == 8'h01) begin
          next_q.pin.address_valid_n = 1'b1;
          next_q.mux_active = 1'b1;
          next_q.st = ST_IDLE;
        end
      end
      ST_BUSYW: begin
        // device busy: no access until released
        if (busy_n) begin
          next_q.pin.addr = q.addr;
          if (q.mux_active) begin
            // mux address phase: bits 12:1 on AD 11:0
            next_q.pin.address_valid_n = 1'b0;
            next_q.pin.ad_out = {4'h0, q.addr[DEV_AW-1:1]};
            next_q.pin.ad_oe = 1'b1;
            next_q.st = ST_ADDR;
            next_q.cnt = AVD_CYC;
          end else begin
            next_q.st = ST_STROBE;
            next_q.cnt = STROBE_CYC;
          end
        end
      end
      ST_ADDR: begin
        if (q.cnt == 8'h01) begin
          next_q.pin.address_valid_n = 1'b1;
          next_q.pin.ad_oe = 1'b0;
          next_q.st = ST_STROBE;
          next_q.cnt = STROBE_CYC;
        end
      end
      ST_STROBE: begin
        // write strobe pair / read strobe pair
        next_q.pin.ce_n = 1'b0;
        next_q.pin.we_n = ~q.is_write;
        next_q.pin.oe_n = q.is_write;
        next_q.pin.ad_oe = q.is_write;
        next_q.pin.ad_out = q.wdata;
        if (q.cnt == 8'h01) begin
          next_q.pin.ce_n = 1'b1;
          next_q.pin.we_n = 1'b1;
          next_q.pin.oe_n = 1'b1;
          next_q.pin.ad_oe = 1'b0;
          if (!q.is_write) begin
            // narrow mode: upper byte not used
            next_q.rdata = q.ctrl_wide ? ad_in : {8'h00, ad_in[7:0]};
          end
          next_q.st = ST_RECOVER;
          next_q.cnt = RECOVER_CYC;
        end
      end
      ST_RECOVER: begin
        if (q.cnt == 8'h01) begin
          next_q.done = 1'b1;
          next_q.st = ST_IDLE;
        end
      end
      default: next_q.st = ST_IDLE;
    endcase
  end

  // State register; device held in reset and sequence begins after release
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.st <= ST_RESET;
      q.cnt <= RESET_CYC;
      q.pin.ce_n <= 1'b1;
      q.pin.oe_n <= 1'b1;
      q.pin.we_n <= 1'b1;
      q.pin.address_valid_n <= 1'b1;
      q.pin.lock_n <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // Outputs straight from flops
  assign bus_rdata       = q.bus_rdata;
  assign ce_n            = q.pin.ce_n;
  assign oe_n            = q.pin.oe_n;
  assign we_n            = q.pin.we_n;
  assign address_valid_n = q.pin.address_valid_n;
  assign dev_addr        = q.pin.addr;
  assign ad_out          = q.pin.ad_out;
  assign ad_oe           = q.pin.ad_oe;
  assign reset_in_n      = q.pin.reset_in_n;
  assign lock_n          = q.pin.lock_n;
  assign if_cfg          = q.pin.if_cfg;

  // Address stable on pins while chip enabled
  chk_addr_stable: assert property (@(posedge clock) disable iff (!rst_n)
    !ce_n |-> (dev_addr == q.addr) && !address_valid_n == 1'b0)
    else $error("address changed during chip enable");

  // Mux address phase carries shifted address
  chk_mux_addr_phase: assert property (@(posedge clock) disable iff (!rst_n)
    (!address_valid_n && q.mux_active) |-> ad_oe && ad_out[11:0] == q.addr[12:1] && ce_n)
    else $error("bad multiplexed address phase");

  // Mode edge only with device out of reset
  chk_edge_after_reset: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(address_valid_n) && !q.mux_active |-> reset_in_n && $past(reset_in_n))
    else $error("mode edge during device reset");

  // Access in mux setting only after mode edge
  chk_access_after_edge: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(ce_n) |-> reset_in_n && (q.mux_active || !$past(q.ctrl_mux, 1) || !q.ctrl_mux))
    else $error("access before mode edge");

  // Lock pin tracks lock bit within one cycle
  chk_lock_held: assert property (@(posedge clock) disable iff (!rst_n)
    q.ctrl_lock |=> !lock_n)
    else $error("lock pin not held");

endmodule

// ==== tb/flash_disk_model.sv ====
// Behavioural flash disk device answering the host port
`timescale 1ns/10ps
module flash_disk_model
  import flash_host_pkg::*;
#(
  parameter int          BUSY_CYC   = 20,
  parameter logic [12:0] PART_LO    = 13'h1000,
  parameter logic [12:0] PART_HI    = 13'h17FF,
  parameter logic [15:0] DENY       = 16'h0000,
  parameter logic [12:0] UID_LO     = 13'h0100,
  parameter logic [15:0] UID_WORD   = 16'h5A3C, // Arbitrary identifier value
  parameter logic [12:0] OTP_LO     = 13'h1800,
  parameter logic [12:0] OTP_HI     = 13'h18FF,
  parameter logic [12:0] BOOT_LO    = 13'h0400,
  parameter logic [12:0] BOOT_HI    = 13'h04FF,
  parameter logic [12:0] STICKY_ADR = 13'h1F00
) (
  // Clock and strobes
  input  wire logic              clock,
  input  wire logic              ce_n,
  input  wire logic              oe_n,
  input  wire logic              we_n,
  input  wire logic              address_valid_n,
  // Address and data
  input  wire logic [DEV_AW-1:0] dev_addr,
  input  wire logic [DEV_DW-1:0] ad_out,
  input  wire logic              ad_oe,
  // Control pins
  input  wire logic              reset_in_n,
  input  wire logic              lock_n,
  input  wire logic              if_cfg,
  output logic [DEV_DW-1:0]      ad_in,
  output logic                   busy_n,
  output logic                   irq_n,
  output logic                   dma_request_n,
  output logic                   violation = 1'b0
);
  logic [15:0] mem [8192];
  logic [15:0] last, word;
  logic [12:0] maddr, a;
  logic [7:0]  bcnt;
  logic        mux, used, avd_d, drive, hit;
  logic        in_uid, in_otp, in_boot, wblock, sticky;
  logic        otp_pend = 1'b0, otp_done = 1'b0, dead = 1'b0;
  // mux address taken from AD, upper cascade bit unused
  assign a = mux ? maddr : dev_addr;
  assign busy_n = (bcnt == 8'h00);
  // no DMA pacing without a DMA job
  assign dma_request_n = 1'b1;
  // window locked by pin or sticky bit
  // only this window follows the lock live; the others ignore the lock
  assign hit = (!lock_n || sticky) && a >= PART_LO && a <= PART_HI;
  assign in_uid = a >= UID_LO && a <= UID_LO + 13'h0007;
  assign in_otp = a >= OTP_LO && a <= OTP_HI;
  assign in_boot = a >= BOOT_LO && a <= BOOT_HI;
  // writes refused by the protection logic
  assign wblock = hit || dead || in_uid || (in_otp && otp_done) || (in_boot && busy_n);
  // read drive, pull-ups on upper byte in narrow mode
  assign drive = !ce_n && !oe_n;
  assign word = (hit || dead) ? DENY : (in_uid ? UID_WORD : mem[a]);
  assign ad_in = drive ? {if_cfg ? word[15:8] : 8'hFF, word[7:0]} : ~last;
  // Device state; busy count reloaded to BUSY_CYC, mode, irq and sticky bit cleared by its reset pin, tamper and one-time flags kept
  always @(posedge clock or negedge reset_in_n) begin
    if (!reset_in_n) begin
      bcnt <= 8'(BUSY_CYC);
      mux <= 1'b0;
      used <= 1'b0;
      avd_d <= 1'b1;
      irq_n <= 1'b1;
      sticky <= 1'b0;
    end else begin
      if (bcnt != 8'h00) bcnt <= bcnt - 8'h01;
      avd_d <= address_valid_n;
      if (drive) last <= ad_in;
      if (!ce_n) used <= 1'b1;
      // falling edge before first access selects mux
      if (!address_valid_n && avd_d && !used) mux <= 1'b1;
      if (mux && !address_valid_n) maddr <= {ad_out[11:0], 1'b0};
      if (!ce_n && !we_n && ad_oe) begin
        if (wblock) irq_n <= 1'b0;
        else mem[a] <= ad_out;
        // writing the identifier counts as tampering
        if (in_uid) dead <= 1'b1;
        // sticky bit set by software, cleared by reset only
        if (a == STICKY_ADR && ad_out[0]) sticky <= 1'b1;
        // area locks once its first write ends
        if (in_otp && !otp_done) otp_pend <= 1'b1;
      end
      if (otp_pend && ce_n) otp_done <= 1'b1;
    end
  end
  // host access while busy or late mode edge
  always @(posedge clock) begin
    if (reset_in_n && ((!ce_n && bcnt != 8'h00) || (!address_valid_n && avd_d && used && !mux)))
      violation <= 1'b1;
  end
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the flash disk host port controller
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module tb;
  import flash_host_pkg::*;
  typedef struct {
    string       name;
    logic [31:0] exp;
    logic [31:0] mask;
  } note_t;
  localparam logic [12:0] PART       = 13'h1234;
  localparam logic [12:0] OTP        = 13'h1840;
  localparam logic [12:0] STICKY_ADR = 13'h1F00;
  localparam logic [12:0] UID_ADR    = 13'h0100;
  localparam logic [15:0] UID_VAL    = 16'h5A3C; // Arbitrary identifier value
  int          error_cnt, total_checks, i;
  int unsigned seed;
  logic        clock = 1'b0, resetn = 1'b0, bus_write = 1'b0, bus_read = 1'b0, rd_d = 1'b0;
  logic [7:0]  bus_addr = 8'h00;
  logic [31:0] bus_wdata = 32'h0, bus_rdata, q;
  logic        ce_n, oe_n, we_n, address_valid_n, ad_oe, reset_in_n, lock_n, if_cfg;
  logic        busy_n, irq_n, dma_request_n, violation;
  logic [12:0] dev_addr;
  logic [15:0] ad_in, ad_out;
  logic [12:0] adr [3] = '{13'h0000, 13'h1FFF, PART};
  logic [15:0] dat [3];
  note_t       notes [$];
  note_t       n;
  always #12.5 clock = ~clock;
  flash_host_port dut (.clock, .resetn, .bus_addr, .bus_wdata, .bus_write, .bus_read,
    .bus_rdata, .ce_n, .oe_n, .we_n, .address_valid_n, .dev_addr, .ad_in, .ad_out, .ad_oe,
    .reset_in_n, .lock_n, .if_cfg, .busy_n, .irq_n, .dma_request_n);
  flash_disk_model #(.UID_LO(UID_ADR), .UID_WORD(UID_VAL), .OTP_LO(OTP), .OTP_HI(OTP),
    .STICKY_ADR(STICKY_ADR)) dev (.clock, .ce_n, .oe_n, .we_n, .address_valid_n,
    .dev_addr, .ad_out, .ad_oe, .reset_in_n, .lock_n, .if_cfg, .ad_in, .busy_n, .irq_n,
    .dma_request_n, .violation);
  // Pop the oldest note on each read answer; compare when its mask is nonzero
  always @(posedge clock) begin
    rd_d <= bus_read;
    if (rd_d && notes.size() > 0) begin
      n = notes.pop_front();
      if (n.mask != 32'h0) `CHK(n.name, n.exp & n.mask, bus_rdata & n.mask)
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_write <= 1'b1;
    @(posedge clock);
    bus_write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input string nm, input logic [31:0] e, m,
                    output logic [31:0] r);
    notes.push_back('{nm, e, m});
    bus_addr <= a;
    bus_read <= 1'b1;
    @(posedge clock);
    bus_read <= 1'b0;
    #1 r = bus_rdata;
    @(posedge clock);
  endtask
  // Bounded wait on one status bit
  task automatic poll(input int b, input logic v);
    logic [31:0] r;
    for (int k = 0; k < 200; k++) begin
      rd(REG_STATUS, "", 32'h0, 32'h0, r);
      if (r[b] === v) break;
    end
    `CHK("status wait", 1'b1, r[b] === v)
  endtask
  task automatic dev_wr(input logic [12:0] a, input logic [15:0] d);
    wr(REG_ADDR, {19'h0, a});
    wr(REG_DATA, {16'h0, d});
    poll(STAT_DONE, 1'b1);
  endtask
  task automatic dev_rd(input logic [12:0] a, input logic [31:0] e, input string nm);
    logic [31:0] r;
    wr(REG_ADDR, {19'h0, a});
    wr(REG_CMD, 32'h1);
    poll(STAT_DONE, 1'b1);
    rd(REG_DATA, nm, e, 32'hFFFFFFFF, r);
  endtask
  task automatic close_out;
    $display("Checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    close_out();
  end
  // Main sequence
  initial begin
    seed = $urandom(32'hEFBD);
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    // Internal reset lifts two edges later; status reads zero until then
    repeat (2) @(posedge clock);
    poll(STAT_ACTIVE, 1'b0);
    rd(REG_STATUS, "status idle", 32'h0, 32'h2C, q);
    rd(8'h20, "unmapped", 32'h0, 32'hFFFFFFFF, q);
    $display("Test reset done");
    wr(REG_CTRL, 32'h4);
    for (i = 0; i < 3; i++) dat[i] = 16'($urandom);
    for (i = 0; i < 3; i++) dev_wr(adr[i], dat[i]);
    for (i = 0; i < 3; i++) dev_rd(adr[i], {16'h0, dat[i]}, "wide read");
    $display("Test standard access done");
    wr(REG_CTRL, 32'h0);
    dev_rd(adr[0], {24'h0, dat[0][7:0]}, "narrow read");
    $display("Test narrow mode done");
    wr(REG_CTRL, 32'h6);
    dev_wr(PART, ~dat[2]);
    rd(REG_STATUS, "irq flag", 32'h4, 32'h4, q);
    dev_rd(PART, 32'h0, "locked read");
    wr(REG_CTRL, 32'h4);
    dev_rd(PART, {16'h0, dat[2]}, "kept data");
    $display("Test lock done");
    dev_wr(OTP, dat[1]);
    dev_wr(OTP, ~dat[1]);
    dev_rd(OTP, {16'h0, dat[1]}, "one-time area");
    dev_wr(STICKY_ADR, 16'h0001);
    dev_rd(PART, 32'h0, "sticky lock");
    $display("Test one-time and sticky lock done");
    wr(REG_CTRL, 32'hD);
    poll(STAT_ACTIVE, 1'b0);
    rd(REG_STATUS, "mux mode", 32'h30, 32'h34, q);
    dev_wr(13'h1246, dat[0]);
    dev_wr(13'h0246, dat[1]);
    dev_rd(13'h1246, {16'h0, dat[0]}, "mux read");
    `CHK("host order", 1'b0, violation)
    $display("Test mux mode done");
    dev_rd(UID_ADR, {16'h0, UID_VAL}, "identifier");
    dev_wr(UID_ADR, ~UID_VAL);
    dev_rd(UID_ADR, 32'h0, "tamper lockout");
    $display("Test identifier done");
    close_out();
  end
endmodule
